//--- lipo_pin_model.sv
/*
 * Far-side model of the port pin: external pull-up plus a switch to ground.
 * Assumes the device pulls low only while its enable is low.
 */
`timescale 1ns/1ns
module lipo_pin_model (
	input wire logic dev_o_i,
	input wire logic dev_oe_b_i,
	input wire logic pull_low_i,
	output logic pin_o
);
	// ----------------------------------------------------------------
	// wired level
	// ----------------------------------------------------------------
	// level follows the device drive and the bench pull-low at once; nothing holds it
	// released wire floats high only through the pull-up, input use needs latch one
	assign pin_o = ((!dev_oe_b_i && !dev_o_i) || pull_low_i) ? 1'b0 : 1'b1;
endmodule : lipo_pin_model

//--- lipo_pin_sync.sv
/*
 * Two-stage synchroniser and falling edge detector for the port pin.
 * Assumes the pin is asynchronous to clk_sys_i.
 */
`timescale 1ns/1ns
module lipo_pin_sync (
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	input wire logic pin_i,
	output logic level_o,
	output logic fall_o
);

	logic meta_r;
	logic sync_r;
	logic prev_r;

	// ----------------------------------------------------------------
	// sync stages; meta_r only feeds sync_r
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			meta_r <= lipo_pkg::SYNC_RST[0];
			sync_r <= lipo_pkg::SYNC_RST[1];
		end else begin
			meta_r <= pin_i;
			sync_r <= meta_r;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			prev_r <= lipo_pkg::SYNC_RST[1];
		end else begin
			prev_r <= sync_r;
		end
	end

	assign level_o = sync_r;
	assign fall_o = prev_r & ~sync_r;

endmodule : lipo_pin_sync

//--- lipo_pkg.sv
/*
 * Shared constants, types and encodings of the latched single-bit I/O port.
 * Assumes a core that issues one bus request at a time.
 */
package lipo_pkg;

	// ----------------------------------------------------------------
	// address map
	// ----------------------------------------------------------------
	localparam int ADDR_W = 20;
	localparam int DATA_W = 8;
	localparam logic [19:0] SFS_FIRST = 20'h00000;
	localparam logic [19:0] SFS_LAST = 20'h0003F;
	localparam logic [19:0] BRS_FIRST = 20'h00F80;
	localparam logic [19:0] BRS_LAST = 20'h00FFF;
	localparam logic [19:0] SINGLE_BIT_PORT_DATA_ADDR = 20'h00002;

	// ----------------------------------------------------------------
	// field layout and reset values
	// ----------------------------------------------------------------
	localparam int PORT_BIT = 0;
	localparam logic LATCH_RST = 1'b1;
	localparam logic [6:0] UPPER_FILL = 7'h00;
	localparam logic [7:0] RDATA_RST = 8'h00;
	localparam logic [1:0] SYNC_RST = 2'h3;

	// ----------------------------------------------------------------
	// instruction classes, as they decide latch or pin on a read
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		INS_OTHER,
		INS_XCH,
		INS_BIT_MANIP,
		INS_LD_FROM_CF,
		INS_ALU_IMM_DST,
		INS_ALU_IND_DST,
		INS_ALU_IND_SRC
	} lipo_ins_e;

	// ----------------------------------------------------------------
	// bus cycle states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_READ_SAMPLE,
		ST_WRITE_UPDATE,
		ST_DONE
	} lipo_state_e;

	typedef struct packed {
		logic [19:0] addr;
		logic [7:0] wdata;
		logic rd;
		logic wr;
		lipo_ins_e ins;
	} lipo_req_s;

	typedef struct packed {
		logic sfs_hit;
		logic brs_hit;
		logic port_hit;
	} lipo_hit_s;

endpackage : lipo_pkg

//--- lipo_port.sv
/*
 * Single-bit latched I/O port with address decode of the peripheral spaces.
 * Assumes the core issues one request at a time and waits for ack_o.
 */
// Operation
// - The special function space is decoded from 00000H through 0003FH.
// - The buffer register space is decoded from 00F80H through 00FFFH as a separate range.
// - The port bit has a latch holding the last written value and that latch drives the pin.
// - A port read samples the pin, or the latch for latch-reading classes, in the read sample state of the bus cycle.
// - A port write updates the latch and pin in the write update state of the bus cycle.
// - Exchange, bit manipulation, load from carry and ALU destinations with immediate or indirect source read the latch.
// - All other reads, including the indirect source of ALU operations, read the pin.
// - The one pin is bidirectional and also feeds external interrupt five and stop release.
// - Reset sets the port latch to one.
// - A falling pin edge flags external interrupt five even while the port drives the pin.
// - On a port read only bit 0 is defined and bits 7 to 1 carry filler.
`timescale 1ns/1ns
module lipo_port (
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	input wire logic req_valid_i,
	input wire lipo_pkg::lipo_req_s req_i,
	output logic busy_o,
	output logic ack_o,
	output logic [7:0] rdata_o,
	output lipo_pkg::lipo_hit_s hit_o,
	input wire logic single_bit_port_pin0_i,
	output logic single_bit_port_pin0_o,
	output logic single_bit_port_pin0_oe_b_o,
	output logic external_irq_input_five_fall_o,
	output logic stop_release_o
);

	// ----------------------------------------------------------------
	// helper functions
	// ----------------------------------------------------------------
	function automatic logic in_range(input logic [19:0] a, input logic [19:0] lo, input logic [19:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction : in_range

	function automatic logic reads_latch(input lipo_pkg::lipo_ins_e ins);
		case (ins)
			lipo_pkg::INS_XCH,
			lipo_pkg::INS_BIT_MANIP,
			lipo_pkg::INS_LD_FROM_CF,
			lipo_pkg::INS_ALU_IMM_DST,
			lipo_pkg::INS_ALU_IND_DST: reads_latch = 1'b1;
			default: reads_latch = 1'b0;
		endcase
	endfunction : reads_latch

	function automatic lipo_pkg::lipo_hit_s decode(input logic [19:0] a);
		lipo_pkg::lipo_hit_s h;
		h.sfs_hit = in_range(a, lipo_pkg::SFS_FIRST, lipo_pkg::SFS_LAST);
		h.brs_hit = in_range(a, lipo_pkg::BRS_FIRST, lipo_pkg::BRS_LAST);
		h.port_hit = (a == lipo_pkg::SINGLE_BIT_PORT_DATA_ADDR);
		return h;
	endfunction : decode

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	lipo_pkg::lipo_state_e state_r;
	lipo_pkg::lipo_state_e state_nxt;
	lipo_pkg::lipo_req_s req_r;
	lipo_pkg::lipo_hit_s hit_r;
	lipo_pkg::lipo_hit_s hit_nxt;
	logic latch_r;
	logic [7:0] rdata_r;
	logic pin_level;
	logic pin_fall;
	logic accept;
	logic port_rd_sample;
	logic port_wr_update;

	assign accept = req_valid_i && (state_r == lipo_pkg::ST_IDLE);
	assign hit_nxt = decode(req_i.addr);
	assign port_rd_sample = (state_r == lipo_pkg::ST_READ_SAMPLE) && req_r.rd && hit_r.port_hit;
	assign port_wr_update = (state_r == lipo_pkg::ST_WRITE_UPDATE) && req_r.wr && hit_r.port_hit;

	// ----------------------------------------------------------------
	// pin synchroniser and edge detect
	// ----------------------------------------------------------------
	// the pin is read back from the wire, so our own drive is seen too
	lipo_pin_sync u_pin_sync (
		.clk_sys_i(clk_sys_i),
		.rst_b_i(rst_b_i),
		.pin_i(single_bit_port_pin0_i),
		.level_o(pin_level),
		.fall_o(pin_fall)
	);

	// ----------------------------------------------------------------
	// bus cycle sequencing
	// ----------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			lipo_pkg::ST_IDLE: begin
				if (req_valid_i) begin
					state_nxt = lipo_pkg::ST_READ_SAMPLE;
				end
			end
			lipo_pkg::ST_READ_SAMPLE: state_nxt = lipo_pkg::ST_WRITE_UPDATE;
			lipo_pkg::ST_WRITE_UPDATE: state_nxt = lipo_pkg::ST_DONE;
			lipo_pkg::ST_DONE: state_nxt = lipo_pkg::ST_IDLE;
			default: state_nxt = lipo_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_r <= lipo_pkg::ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// request held for the whole cycle; new requests wait until idle
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			req_r <= '0;
			hit_r <= '0;
		end else if (accept) begin
			req_r <= req_i;
			hit_r <= hit_nxt;
		end
	end

	// ----------------------------------------------------------------
	// read data path
	// ----------------------------------------------------------------
	// unmapped addresses read as zero; other registers live elsewhere
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata_r <= lipo_pkg::RDATA_RST;
		end else if (state_r == lipo_pkg::ST_READ_SAMPLE && req_r.rd) begin
			if (hit_r.port_hit) begin
				if (reads_latch(req_r.ins)) begin
					rdata_r <= {lipo_pkg::UPPER_FILL, latch_r};
				end else begin
					rdata_r <= {lipo_pkg::UPPER_FILL, pin_level};
				end
			end else begin
				rdata_r <= lipo_pkg::RDATA_RST;
			end
		end
	end

	// ----------------------------------------------------------------
	// output latch
	// ----------------------------------------------------------------
	// written after the sample, so an exchange returns the old value
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			latch_r <= lipo_pkg::LATCH_RST;
		end else if (port_wr_update) begin
			latch_r <= req_r.wdata[lipo_pkg::PORT_BIT];
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// a one releases the pin so it can serve as input; a zero pulls low
	assign single_bit_port_pin0_o = latch_r;
	assign single_bit_port_pin0_oe_b_o = latch_r;
	// edge flag is not gated by the latch: driving low also interrupts
	assign external_irq_input_five_fall_o = pin_fall;
	assign stop_release_o = pin_level;
	assign busy_o = (state_r != lipo_pkg::ST_IDLE);
	assign ack_o = (state_r == lipo_pkg::ST_DONE);
	assign rdata_o = rdata_r;
	assign hit_o = hit_r;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	chk_sfs_decode: assert property (
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		accept |=> (hit_r.sfs_hit == ($past(req_i.addr) <= 20'h0003F))
	) else $error("special function space decode wrong");

	chk_brs_decode: assert property (
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		accept |=> (hit_r.brs_hit == ($past(req_i.addr) >= 20'h00F80 && $past(req_i.addr) <= 20'h00FFF))
	) else $error("buffer register space decode wrong");

	chk_spaces_apart: assert property (
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		!(hit_r.sfs_hit && hit_r.brs_hit)
	) else $error("address decoded into both spaces");

	chk_latch_drives: assert property (
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		!(state_r == lipo_pkg::ST_WRITE_UPDATE) |=> $stable(single_bit_port_pin0_o)
	) else $error("pin changed outside write update state");

	chk_write_timing: assert property (
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		(accept && req_i.wr && req_i.addr == lipo_pkg::SINGLE_BIT_PORT_DATA_ADDR)
		|=> ##2 (single_bit_port_pin0_o == $past(req_i.wdata[0], 3)) && ack_o
	) else $error("port write not applied in write update state");

	chk_pin_sample: assert property (
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		(port_rd_sample && !reads_latch(req_r.ins)) |=> (rdata_o[0] == $past(pin_level)) ##1 ack_o
	) else $error("pin not sampled in read sample state");

	chk_latch_read: assert property (
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		(port_rd_sample && reads_latch(req_r.ins)) |=> (rdata_o[0] == $past(latch_r))
	) else $error("latch not returned for latch-reading instruction");

	chk_upper_fill: assert property (
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		ack_o && req_r.rd |-> (rdata_o[7:1] == 7'h00)
	) else $error("upper read bits not filler");

	chk_irq_when_driving: assert property (
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		($fell(pin_level)) |-> external_irq_input_five_fall_o
	) else $error("falling pin edge not flagged");

	chk_reset_latch: assert property (
		@(posedge clk_sys_i)
		$rose(rst_b_i) |-> single_bit_port_pin0_o && single_bit_port_pin0_oe_b_o
	) else $error("latch not one after reset");

	// ----------------------------------------------------------------
	// bus cycle checks
	// ----------------------------------------------------------------
	chk_cycle_length: assert property (
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		accept |=> (busy_o && !ack_o) ##1 (busy_o && !ack_o) ##1 ack_o ##1 !busy_o
	) else $error("bus cycle length wrong");

	chk_bus_refused: assert property (
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		(req_valid_i && busy_o) |=> $stable(hit_o)
	) else $error("request taken while busy");

	chk_port_in_sfs: assert property (
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		hit_o.port_hit |-> (hit_o.sfs_hit && !hit_o.brs_hit)
	) else $error("port register outside special function space");

	chk_brs_no_port: assert property (
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		hit_o.brs_hit |-> (!hit_o.port_hit && !hit_o.sfs_hit)
	) else $error("buffer register space overlaps the port");

	chk_nonport_read: assert property (
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		(state_r == lipo_pkg::ST_READ_SAMPLE && req_r.rd && !hit_r.port_hit)
		|=> (rdata_o == lipo_pkg::RDATA_RST)
	) else $error("read outside the port register not zero");

	chk_ack_rdata_stable: assert property (
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		ack_o |-> $stable(rdata_o)
	) else $error("read data moved before ack");

	chk_nonport_write: assert property (
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		(state_r == lipo_pkg::ST_WRITE_UPDATE && !port_wr_update) |=> $stable(single_bit_port_pin0_o)
	) else $error("pin moved without a port write");

	chk_write_bit: assert property (
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		port_wr_update |=> (latch_r == $past(req_r.wdata[lipo_pkg::PORT_BIT]))
	) else $error("latch did not take bit 0 of the write");

	chk_xch_old_latch: assert property (
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		(port_rd_sample && req_r.wr && req_r.ins == lipo_pkg::INS_XCH)
		|=> (rdata_o[0] == $past(latch_r)) ##1 (single_bit_port_pin0_o == req_r.wdata[lipo_pkg::PORT_BIT])
	) else $error("exchange did not return old latch and store new bit");

	// ----------------------------------------------------------------
	// pin checks
	// ----------------------------------------------------------------
	chk_fall_pulse: assert property (
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		external_irq_input_five_fall_o |=> !external_irq_input_five_fall_o
	) else $error("edge flag longer than one cycle");

	// any fall of the wire counts, our own drive included
	chk_fall_latency: assert property (
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		$fell(single_bit_port_pin0_i) |-> ##2 external_irq_input_five_fall_o
	) else $error("pin fall not flagged two edges later");

	// two edges after release the sync stages still hold reset ones
	chk_stop_level: assert property (
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		$past(rst_b_i, 2) |-> (stop_release_o == $past(single_bit_port_pin0_i, 2))
	) else $error("stop release does not follow the pin");

endmodule : lipo_port

//--- tb_top.sv
/*
 * Self-checking bench of the single-bit port, with a behavioural expectation model.
 * Assumes lipo_pkg, lipo_port and lipo_pin_model are compiled first.
 */
`timescale 1ns/1ns
module tb_top;
	logic clk_sys_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic req_valid_i = 1'b0;
	lipo_pkg::lipo_req_s req_i = '0;
	logic pull_low = 1'b0;
	logic pin_w, busy_o, ack_o, pin_o, oe_b, fall, stop_rel;
	logic [7:0] rdata_o, rd_v, ex;
	logic [7:0] exp_q [$];
	lipo_pkg::lipo_hit_s hit_o, hit_v;
	logic [19:0] adr [8] = '{20'h00000, 20'h00002, 20'h0003F, 20'h00040,
		20'h00F7F, 20'h00F80, 20'h00FFF, 20'h01000};
	logic [31:0] rng = 32'h0000B8DF;
	int n_errors = 0;
	int total_checks = 0;
	int n_fall = 0;
	int exp_fall = 0;
	int m_latch = 1;
	int lat;
	localparam logic [19:0] PA = lipo_pkg::SINGLE_BIT_PORT_DATA_ADDR;

	always #5 clk_sys_i = ~clk_sys_i;

	lipo_port DUT (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .req_valid_i(req_valid_i), .req_i(req_i),
		.busy_o(busy_o), .ack_o(ack_o), .rdata_o(rdata_o), .hit_o(hit_o), .single_bit_port_pin0_i(pin_w),
		.single_bit_port_pin0_o(pin_o), .single_bit_port_pin0_oe_b_o(oe_b),
		.external_irq_input_five_fall_o(fall), .stop_release_o(stop_rel));
	lipo_pin_model ext (.dev_o_i(pin_o), .dev_oe_b_i(oe_b), .pull_low_i(pull_low), .pin_o(pin_w));

	always @(posedge clk_sys_i) if (fall === 1'b1) n_fall <= n_fall + 1;

	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction : xs

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic summarize;
		$display("checks=%0d errors=%0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : summarize

	// one whole bus cycle; request stands until the edge that sees ack, three edges after acceptance
	task automatic bus(input logic [19:0] a, input logic [7:0] d, input logic rd, input logic wr,
		input lipo_pkg::lipo_ins_e ins);
		int i;
		@(negedge clk_sys_i);
		req_valid_i = 1'b1;
		req_i = '{addr: a, wdata: d, rd: rd, wr: wr, ins: ins};
		i = 0;
		@(negedge clk_sys_i);
		while (ack_o !== 1'b1 && i < 8) begin
			@(negedge clk_sys_i);
			i++;
		end
		check(i, 2);
		rd_v = rdata_o;
		hit_v = hit_o;
		@(negedge clk_sys_i);
		req_valid_i = 1'b0;
		if (wr && a == PA) begin
			if (m_latch == 1 && d[0] == 1'b0) exp_fall++;
			m_latch = d[0];
		end
		check({pin_o, oe_b}, {2{m_latch[0]}});
	endtask : bus

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		repeat (20) @(negedge clk_sys_i);
		check({busy_o, ack_o, pin_o, oe_b, stop_rel, rdata_o}, {5'h07, 8'h00});
		rst_b_i = 1'b1;
		$display("test reset done");
		// exchange of zero at every edge of both spaces; only the port takes it
		for (int k = 0; k < 8; k++) begin
			ex = (adr[k] == PA) ? {7'h00, m_latch[0]} : 8'h00;
			bus(adr[k], 8'h00, 1'b1, 1'b1, lipo_pkg::INS_XCH);
			check(rd_v, ex);
			check(hit_v, {adr[k] <= lipo_pkg::SFS_LAST, adr[k] >= lipo_pkg::BRS_FIRST &&
				adr[k] <= lipo_pkg::BRS_LAST, adr[k] == PA});
		end
		$display("test decode done");
		// latch one, pin held low outside: latch classes differ from pin classes
		bus(PA, 8'hFF, 1'b0, 1'b1, lipo_pkg::INS_OTHER);
		@(negedge clk_sys_i);
		pull_low = 1'b1;
		exp_fall++;
		repeat (4) @(negedge clk_sys_i);
		check(stop_rel, 1'b0);
		for (int k = 0; k < 7; k++) begin
			bus(PA, 8'h00, 1'b1, 1'b0, lipo_pkg::lipo_ins_e'(k));
			check(rd_v, (k >= 1 && k <= 5) ? 8'h01 : 8'h00);
		end
		pull_low = 1'b0;
		$display("test read source done");
		// random bytes: only bit 0 lands, pin read back follows the latch
		for (int k = 0; k < 16; k++) begin
			rng = xs(rng);
			bus(PA, rng[7:0], 1'b0, 1'b1, lipo_pkg::INS_OTHER);
			exp_q.push_back({7'h00, m_latch[0]});
			bus(PA, 8'h00, 1'b1, 1'b0, lipo_pkg::INS_OTHER);
			check(rd_v, exp_q.pop_front());
		end
		repeat (6) @(negedge clk_sys_i);
		check(n_fall, exp_fall);
		$display("test random done");
		// second reset with the latch driving low
		bus(PA, 8'hFE, 1'b0, 1'b1, lipo_pkg::INS_OTHER);
		rst_b_i = 1'b0;
		m_latch = 1;
		repeat (2) @(negedge clk_sys_i);
		check({pin_o, oe_b, busy_o}, 3'h6);
		rst_b_i = 1'b1;
		lat = n_fall;
		bus(PA, 8'h00, 1'b1, 1'b0, lipo_pkg::INS_BIT_MANIP);
		check(rd_v, 8'h01);
		check(n_fall, lat);
		$display("test second reset done");
		summarize();
	end

	initial begin
		#500000;
		n_errors++;
		summarize();
	end
endmodule : tb_top
